// >>> ext_pin_int_defs.vh
// constants for the external pin interrupt detector: register map,
// field positions, reset values and bus widths.
// assumes inclusion by bare name; the guard makes repeated inclusion safe.
`ifndef EXT_PIN_INT_DEFS_VH
`define EXT_PIN_INT_DEFS_VH

// bus widths
`define EPI_ADDR_W 4
`define EPI_DATA_W 8

// register offsets on the plain register port
`define EPI_OFS_CTRL 4'h0
`define EPI_OFS_STATUS 4'h1
`define EPI_OFS_MASK 4'h2
`define EPI_OFS_PIN 4'h3

// control/status register field positions
`define EPI_BIT_PDD 6
`define EPI_BIT_EDG 5
`define EPI_BIT_PE 4
`define EPI_BIT_FLAG 3
`define EPI_BIT_ACK 2
`define EPI_BIT_IE 1
`define EPI_BIT_MOD 0

// event status / mask field positions
`define EPI_EV_DETECT 0
`define EPI_EV_ACK_REFUSED 1
`define EPI_EV_W 2

// pin readback field positions
`define EPI_PIN_LEVEL 0
`define EPI_PIN_ASSERTED 1

// reset values
`define EPI_RST_BIT 1'b0
`define EPI_RST_EV 2'h0
`define EPI_RST_DATA 8'h00

`endif

// >>> pin_sync3.v
// three-stage synchroniser for one asynchronous pin with agreement filter.
// assumes the pin is asynchronous to core_clk; the filtered level only
// changes once the second and third stages agree.
`include "ext_pin_int_defs.vh"
`default_nettype none

module pin_sync3 (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // raw pin
    input wire pin_raw,
    // filtered level in the core_clk domain
    output reg pin_level_ff
);

    reg meta_ff;
    reg sync2_ff;
    reg sync3_ff;

    // first stage is read only by the second, to keep metastability contained
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= `EPI_RST_BIT;
            sync2_ff <= `EPI_RST_BIT;
            sync3_ff <= `EPI_RST_BIT;
        end else begin
            meta_ff <= pin_raw;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a change counts only when two settled stages agree
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_level_ff <= `EPI_RST_BIT;
        end else if (sync2_ff == sync3_ff) begin
            pin_level_ff <= sync3_ff;
        end
    end

endmodule // pin_sync3

`default_nettype wire

// >>> ext_pin_int.v
// external pin interrupt detector: one dedicated request pin, an 8-bit
// control/status register, event status/mask registers and pull control.
// assumes a single-cycle register port (read data one cycle after the read
// strobe) and an asynchronous request pin driven by an outside device.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`include "ext_pin_int_defs.vh"
`default_nettype none

module ext_pin_int (
    // clock and reset
    input wire core_clk,
    input wire rst_b,

    // register port
    input wire [`EPI_ADDR_W-1:0] reg_addr,
    input wire [`EPI_DATA_W-1:0] reg_wr_data,
    input wire reg_wr_en,
    input wire reg_rd_en,
    output reg [`EPI_DATA_W-1:0] reg_rd_data_ff,

    // external request pin
    input wire irq_pin_in,

    // pull device controls for the pin pad
    output reg pull_up_en_ff,
    output reg pull_down_en_ff,

    // interrupt outputs
    output reg core_irq_req_ff,
    output reg event_irq_ff
);

    //------------------------------------------------------------------
    // functions
    //------------------------------------------------------------------

    // true when a level matches the selected sense (0 = low, 1 = high)
    function pin_active;
        input level;
        input polarity;
        begin
            pin_active = polarity ? level : ~level;
        end
    endfunction

    // address match for a strobe
    function reg_hit;
        input strobe;
        input [`EPI_ADDR_W-1:0] addr;
        input [`EPI_ADDR_W-1:0] offset;
        begin
            reg_hit = strobe & (addr == offset);
        end
    endfunction

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------

    // control fields
    reg pull_device_disable_ff;
    reg edge_polarity_select_ff;
    reg pin_function_enable_ff;
    reg pin_event_flag_ff;
    reg pin_interrupt_enable_ff;
    reg detect_mode_select_ff;

    // event status and mask
    reg [`EPI_EV_W-1:0] event_status_ff;
    reg [`EPI_EV_W-1:0] event_mask_ff;

    // previous synchronised pin level for edge detection
    reg prev_level_ff;

    // next values
    reg nxt_pull_device_disable;
    reg nxt_edge_polarity_select;
    reg nxt_pin_function_enable;
    reg nxt_pin_event_flag;
    reg nxt_pin_interrupt_enable;
    reg nxt_detect_mode_select;
    reg [`EPI_EV_W-1:0] nxt_event_status;
    reg [`EPI_EV_W-1:0] nxt_event_mask;
    reg [`EPI_DATA_W-1:0] nxt_rd_data;

    // synchronised pin level
    wire pin_level;

    //------------------------------------------------------------------
    // pin synchroniser
    //------------------------------------------------------------------

    // pin is asynchronous; three stages with agreement filter glitches
    pin_sync3 u_pin_sync3 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_raw(irq_pin_in),
        .pin_level_ff(pin_level)
    );

    // keep last sample so edges are a compare of consecutive samples
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_level_ff <= `EPI_RST_BIT;
        end else begin
            prev_level_ff <= pin_level;
        end
    end

    //------------------------------------------------------------------
    // register decode
    //------------------------------------------------------------------

    wire wr_ctrl;
    wire wr_status;
    wire wr_mask;
    wire ack_write;

    assign wr_ctrl = reg_hit(reg_wr_en, reg_addr, `EPI_OFS_CTRL);
    assign wr_status = reg_hit(reg_wr_en, reg_addr, `EPI_OFS_STATUS);
    assign wr_mask = reg_hit(reg_wr_en, reg_addr, `EPI_OFS_MASK);
    // acknowledge is a write of one; a zero in that bit does nothing
    assign ack_write = wr_ctrl & reg_wr_data[`EPI_BIT_ACK];

    //------------------------------------------------------------------
    // event detection
    //------------------------------------------------------------------

    wire level_now;
    wire level_before;
    wire edge_event;
    wire level_event;
    wire set_flag;

    // settings in force this cycle; a write takes effect next cycle
    assign level_now = pin_active(pin_level, edge_polarity_select_ff);
    assign level_before = pin_active(prev_level_ff, edge_polarity_select_ff);

    // edge: sample went from inactive to active with the pin enabled
    // a pulse shorter than the filter window can be missed entirely
    assign edge_event = pin_function_enable_ff & level_now & ~level_before;

    // level: active level keeps asserting while level mode is on
    assign level_event = pin_function_enable_ff & detect_mode_select_ff
        & level_now;

    assign set_flag = edge_event | level_event;

    //------------------------------------------------------------------
    // control register next values
    //------------------------------------------------------------------

    // read/write control bits load from a control write
    always @* begin
        nxt_pull_device_disable = pull_device_disable_ff;
        nxt_edge_polarity_select = edge_polarity_select_ff;
        nxt_pin_function_enable = pin_function_enable_ff;
        nxt_pin_interrupt_enable = pin_interrupt_enable_ff;
        nxt_detect_mode_select = detect_mode_select_ff;
        if (wr_ctrl) begin
            nxt_pull_device_disable = reg_wr_data[`EPI_BIT_PDD];
            nxt_edge_polarity_select = reg_wr_data[`EPI_BIT_EDG];
            nxt_pin_function_enable = reg_wr_data[`EPI_BIT_PE];
            nxt_pin_interrupt_enable = reg_wr_data[`EPI_BIT_IE];
            nxt_detect_mode_select = reg_wr_data[`EPI_BIT_MOD];
        end
    end

    // flag: set wins over acknowledge, which also keeps it set while a
    // level-mode pin is held asserted, since the level sets it each cycle
    always @* begin
        nxt_pin_event_flag = pin_event_flag_ff;
        if (ack_write) begin
            nxt_pin_event_flag = 1'b0;
        end
        if (set_flag) begin
            nxt_pin_event_flag = 1'b1;
        end
    end

    //------------------------------------------------------------------
    // event status and mask next values
    //------------------------------------------------------------------

    // sticky events, cleared by writing one; a new event beats the clear
    always @* begin
        nxt_event_status = event_status_ff;
        if (wr_status) begin
            nxt_event_status = event_status_ff & ~reg_wr_data[`EPI_EV_W-1:0];
        end
        if (set_flag) begin
            nxt_event_status[`EPI_EV_DETECT] = 1'b1;
        end
        // acknowledge thrown away because the pin still holds its level
        if (ack_write & level_event) begin
            nxt_event_status[`EPI_EV_ACK_REFUSED] = 1'b1;
        end
    end

    // mask has the same layout as the status register
    always @* begin
        nxt_event_mask = event_mask_ff;
        if (wr_mask) begin
            nxt_event_mask = reg_wr_data[`EPI_EV_W-1:0];
        end
    end

    //------------------------------------------------------------------
    // control register flops
    //------------------------------------------------------------------

    // everything clears at reset: pin disabled, edge-only, falling sense
    // flag survives a pin disable so software can still poll it
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_device_disable_ff <= `EPI_RST_BIT;
            edge_polarity_select_ff <= `EPI_RST_BIT;
            pin_function_enable_ff <= `EPI_RST_BIT;
            pin_event_flag_ff <= `EPI_RST_BIT;
            pin_interrupt_enable_ff <= `EPI_RST_BIT;
            detect_mode_select_ff <= `EPI_RST_BIT;
        end else begin
            pull_device_disable_ff <= nxt_pull_device_disable;
            edge_polarity_select_ff <= nxt_edge_polarity_select;
            pin_function_enable_ff <= nxt_pin_function_enable;
            pin_event_flag_ff <= nxt_pin_event_flag;
            pin_interrupt_enable_ff <= nxt_pin_interrupt_enable;
            detect_mode_select_ff <= nxt_detect_mode_select;
        end
    end

    // status and mask flops
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            event_status_ff <= `EPI_RST_EV;
            event_mask_ff <= `EPI_RST_EV;
        end else begin
            event_status_ff <= nxt_event_status;
            event_mask_ff <= nxt_event_mask;
        end
    end

    //------------------------------------------------------------------
    // pull device control
    //------------------------------------------------------------------

    // computed from next values so the pad follows a write with no lag
    // beyond the output flop itself
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_up_en_ff <= `EPI_RST_BIT;
            pull_down_en_ff <= `EPI_RST_BIT;
        end else begin
            pull_up_en_ff <= nxt_pin_function_enable & ~nxt_pull_device_disable
                & ~nxt_edge_polarity_select;
            pull_down_en_ff <= nxt_pin_function_enable & ~nxt_pull_device_disable
                & nxt_edge_polarity_select;
        end
    end

    //------------------------------------------------------------------
    // interrupt outputs
    //------------------------------------------------------------------

    // core request follows the flag level; polling works with enable off
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_irq_req_ff <= `EPI_RST_BIT;
        end else begin
            core_irq_req_ff <= nxt_pin_event_flag & nxt_pin_interrupt_enable;
        end
    end

    // summary interrupt: any unmasked sticky event
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            event_irq_ff <= `EPI_RST_BIT;
        end else begin
            event_irq_ff <= |(nxt_event_status & nxt_event_mask);
        end
    end

    //------------------------------------------------------------------
    // read data
    //------------------------------------------------------------------

    // read mux; acknowledge and bit 7 always read zero, unmapped reads zero
    // pin readback shows the filtered level, not the raw pad
    always @* begin
        nxt_rd_data = `EPI_RST_DATA;
        case (reg_addr)
            `EPI_OFS_CTRL: begin
                nxt_rd_data[`EPI_BIT_PDD] = pull_device_disable_ff;
                nxt_rd_data[`EPI_BIT_EDG] = edge_polarity_select_ff;
                nxt_rd_data[`EPI_BIT_PE] = pin_function_enable_ff;
                nxt_rd_data[`EPI_BIT_FLAG] = pin_event_flag_ff;
                nxt_rd_data[`EPI_BIT_ACK] = 1'b0;
                nxt_rd_data[`EPI_BIT_IE] = pin_interrupt_enable_ff;
                nxt_rd_data[`EPI_BIT_MOD] = detect_mode_select_ff;
            end
            `EPI_OFS_STATUS: begin
                nxt_rd_data[`EPI_EV_W-1:0] = event_status_ff;
            end
            `EPI_OFS_MASK: begin
                nxt_rd_data[`EPI_EV_W-1:0] = event_mask_ff;
            end
            `EPI_OFS_PIN: begin
                nxt_rd_data[`EPI_PIN_LEVEL] = pin_level;
                nxt_rd_data[`EPI_PIN_ASSERTED] = level_now;
            end
            default: begin
                nxt_rd_data = `EPI_RST_DATA;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe, zero otherwise
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rd_data_ff <= `EPI_RST_DATA;
        end else if (reg_rd_en) begin
            reg_rd_data_ff <= nxt_rd_data;
        end else begin
            reg_rd_data_ff <= `EPI_RST_DATA;
        end
    end

endmodule // ext_pin_int

`default_nettype wire

// >>> ext_pin_drv.sv
// outside device on the request pin, behavioural
// assumes pad pulls come from the detector; a floating pin shows the inverse of the last driven value
`default_nettype none
module ext_pin_drv (
    // driver controls from the bench
    input wire logic drive_en,
    input wire logic drive_val,
    // pad pull controls
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    // request pin
    output wire logic irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin: pull level, else the inverse of the last driven value
    assign irq_pin = drive_en ? drive_val : pull_up_en ? 1'b1 : pull_down_en ? 1'b0 : !drive_val;
endmodule // ext_pin_drv
`default_nettype wire

// >>> ext_pin_int_chk.sv
// port checker for the external pin interrupt detector
// assumes one clock core_clk and asynchronous active-low rst_b
`include "ext_pin_int_defs.vh"
`default_nettype none
module ext_pin_int_chk (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // register port
    input wire [`EPI_ADDR_W-1:0] reg_addr,
    input wire [`EPI_DATA_W-1:0] reg_wr_data,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [`EPI_DATA_W-1:0] reg_rd_data_ff,
    // pin and outputs
    input wire irq_pin_in,
    input wire pull_up_en_ff,
    input wire pull_down_en_ff,
    input wire core_irq_req_ff,
    input wire event_irq_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // read data only in the cycle after a read
    AST_RD_IDLE_ZERO: assert property (!$past(reg_rd_en) |-> reg_rd_data_ff == 8'h00)
        else $error("read data not zero outside a read");
    AST_CTRL_FIXED_ZERO: assert property (reg_rd_en && reg_addr == `EPI_OFS_CTRL
        |=> reg_rd_data_ff[7] == 1'b0 && reg_rd_data_ff[2] == 1'b0)
        else $error("control bit 7 or 2 read as one");
    AST_UNMAPPED_ZERO: assert property (reg_rd_en && reg_addr > `EPI_OFS_PIN
        |=> reg_rd_data_ff == 8'h00)
        else $error("unmapped read not zero");
    AST_PULL_EXCL: assert property (!(pull_up_en_ff && pull_down_en_ff))
        else $error("pull-up and pull-down both on");
    // a settled control write decides the pad pulls two edges later
    AST_PULL_UP: assert property (reg_wr_en && reg_addr == `EPI_OFS_CTRL
        && reg_wr_data[6:4] == 3'b001 ##1 !reg_wr_en
        |-> ##1 pull_up_en_ff && !pull_down_en_ff)
        else $error("pull-up missing for falling sense");
    AST_PULL_DOWN: assert property (reg_wr_en && reg_addr == `EPI_OFS_CTRL
        && reg_wr_data[6:4] == 3'b011 ##1 !reg_wr_en
        |-> ##1 pull_down_en_ff && !pull_up_en_ff)
        else $error("pull-down missing for rising sense");
    AST_PULL_OFF: assert property (reg_wr_en && reg_addr == `EPI_OFS_CTRL
        && (reg_wr_data[6] || !reg_wr_data[4]) ##1 !reg_wr_en
        |-> ##1 !pull_up_en_ff && !pull_down_en_ff)
        else $error("pull on while disabled");
    AST_IRQ_GATED: assert property (reg_wr_en && reg_addr == `EPI_OFS_CTRL
        && !reg_wr_data[1] ##1 !reg_wr_en |-> ##1 !core_irq_req_ff)
        else $error("core request without enable");
    AST_CTRL_READBACK: assert property (reg_wr_en && reg_addr == `EPI_OFS_CTRL
        ##1 reg_rd_en && reg_addr == `EPI_OFS_CTRL
        |=> reg_rd_data_ff[6:4] == $past(reg_wr_data[6:4], 2)
        && reg_rd_data_ff[1:0] == $past(reg_wr_data[1:0], 2))
        else $error("control readback differs");
    // main scenarios
    COV_CORE_IRQ: cover property ($rose(core_irq_req_ff));
    COV_EVENT_IRQ: cover property ($rose(event_irq_ff));
    COV_PULL_DOWN: cover property ($rose(pull_down_en_ff));
endmodule // ext_pin_int_chk
bind ext_pin_int ext_pin_int_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data_ff(reg_rd_data_ff), .irq_pin_in(irq_pin_in),
    .pull_up_en_ff(pull_up_en_ff), .pull_down_en_ff(pull_down_en_ff),
    .core_irq_req_ff(core_irq_req_ff), .event_irq_ff(event_irq_ff));
`default_nettype wire

// >>> ext_pin_int_tb.sv
// self-checking bench for the external pin interrupt detector
// assumes the design, its defines, the pin driver model and the checker
`include "ext_pin_int_defs.vh"
`default_nettype none
module ext_pin_int_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [`EPI_ADDR_W-1:0] reg_addr = 4'h0;
    logic [`EPI_DATA_W-1:0] reg_wr_data = 8'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic drv_en = 1'b1;
    logic drv_val = 1'b1;
    logic [7:0] rd_val;
    logic [7:0] ctrl;
    wire [`EPI_DATA_W-1:0] reg_rd_data_ff;
    wire irq_pin_in;
    wire pull_up_en_ff;
    wire pull_down_en_ff;
    wire core_irq_req_ff;
    wire event_irq_ff;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    int i;
    // free-running 100 MHz clock
    always #5 core_clk = ~core_clk;
    ext_pin_int u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_rd_data_ff(reg_rd_data_ff), .irq_pin_in(irq_pin_in),
        .pull_up_en_ff(pull_up_en_ff), .pull_down_en_ff(pull_down_en_ff),
        .core_irq_req_ff(core_irq_req_ff), .event_irq_ff(event_irq_ff));
    ext_pin_drv u_pin (.drive_en(drv_en), .drive_val(drv_val), .pull_up_en(pull_up_en_ff),
        .pull_down_en(pull_down_en_ff), .irq_pin(irq_pin_in));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // write strobe stays up; every write is followed by a read, which drops it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1 rd_val = reg_rd_data_ff;
    endtask
    // bounded wait on the core request level
    task automatic wait_irq(input logic lvl);
        for (i = 0; i < 20 && core_irq_req_ff !== lvl; i++) @(posedge core_clk);
        if (core_irq_req_ff !== lvl) begin
            bad_count++;
            print_verdict();
        end
    endtask
    // bits 7 and 2 never read back; the flag sits at bit 3
    function automatic logic [7:0] exp_ctrl(input logic [7:0] c, input logic flag);
        exp_ctrl = (c & 8'h73) | {4'h0, flag, 3'h0};
    endfunction
    // pad pulls as {down, up}
    function automatic logic [7:0] exp_pull(input logic [7:0] c);
        exp_pull = {6'h00, c[4] & !c[6] & c[5], c[4] & !c[6] & !c[5]};
    endfunction
    initial begin
        void'($urandom(32'h4f91));
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`EPI_OFS_CTRL);
        chk("ctrl", 8'h00, rd_val);
        rd(4'hf);
        chk("unmapped", 8'h00, rd_val);
        // a write to an unmapped offset must leave control untouched
        wr(4'hf, 8'hff);
        rd(`EPI_OFS_CTRL);
        chk("ctrl", 8'h00, rd_val);
        wr(`EPI_OFS_MASK, 8'h01);
        rd(`EPI_OFS_MASK);
        chk("mask", 8'h01, rd_val);
        // random settings with the pin disabled while it toggles
        for (n = 0; n < 8; n++) begin
            ctrl = 8'($urandom) & 8'hef;
            wr(`EPI_OFS_CTRL, ctrl);
            rd(`EPI_OFS_CTRL);
            chk("ctrl", exp_ctrl(ctrl, 1'b0), rd_val);
            chk("pull", exp_pull(ctrl), {6'h00, pull_down_en_ff, pull_up_en_ff});
            repeat (6) @(posedge core_clk);
            drv_val <= 1'($urandom);
        end
        // pin enabled with its pull off, once the last toggle has settled
        repeat (6) @(posedge core_clk);
        wr(`EPI_OFS_CTRL, 8'h50);
        rd(`EPI_OFS_CTRL);
        chk("ctrl", exp_ctrl(8'h50, 1'b0), rd_val);
        chk("pull", exp_pull(8'h50), {6'h00, pull_down_en_ff, pull_up_en_ff});
        rd(`EPI_OFS_STATUS);
        chk("status", 8'h00, rd_val);
        // edge mode, both senses: set, request, acknowledge with pin still active
        for (n = 0; n < 2; n++) begin
            @(posedge core_clk);
            drv_val <= !n[0];
            repeat (8) @(posedge core_clk);
            ctrl = {2'b00, n[0], 5'b10110};
            wr(`EPI_OFS_CTRL, ctrl);
            rd(`EPI_OFS_CTRL);
            chk("ctrl", exp_ctrl(ctrl, 1'b0), rd_val);
            chk("pull", exp_pull(ctrl), {6'h00, pull_down_en_ff, pull_up_en_ff});
            @(posedge core_clk);
            drv_val <= n[0];
            wait_irq(1'b1);
            rd(`EPI_OFS_CTRL);
            chk("ctrl", exp_ctrl(ctrl, 1'b1), rd_val);
            rd(`EPI_OFS_STATUS);
            chk("status", 8'h01, rd_val);
            chk("event irq", 8'h01, {7'h00, event_irq_ff});
            wr(`EPI_OFS_CTRL, ctrl);
            rd(`EPI_OFS_CTRL);
            chk("ctrl", exp_ctrl(ctrl, 1'b0), rd_val);
            wait_irq(1'b0);
            wr(`EPI_OFS_STATUS, 8'h03);
            rd(`EPI_OFS_STATUS);
            chk("status", 8'h00, rd_val);
        end
        // level mode, low sense, polled: acknowledge refused while held low
        @(posedge core_clk);
        drv_val <= 1'b1;
        repeat (8) @(posedge core_clk);
        ctrl = 8'h15;
        wr(`EPI_OFS_CTRL, ctrl);
        rd(`EPI_OFS_CTRL);
        chk("ctrl", exp_ctrl(ctrl, 1'b0), rd_val);
        @(posedge core_clk);
        drv_val <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("core irq", 8'h00, {7'h00, core_irq_req_ff});
        rd(`EPI_OFS_PIN);
        chk("pin", 8'h02, rd_val);
        wr(`EPI_OFS_CTRL, ctrl);
        rd(`EPI_OFS_CTRL);
        chk("ctrl", exp_ctrl(ctrl, 1'b1), rd_val);
        rd(`EPI_OFS_STATUS);
        chk("status", 8'h03, rd_val);
        chk("event irq", 8'h01, {7'h00, event_irq_ff});
        // released pin returns high through the pull-up, then the ack takes
        @(posedge core_clk);
        drv_en <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(`EPI_OFS_PIN);
        chk("pin", 8'h01, rd_val);
        wr(`EPI_OFS_CTRL, ctrl);
        rd(`EPI_OFS_CTRL);
        chk("ctrl", exp_ctrl(ctrl, 1'b0), rd_val);
        // masking hides pending status from the summary output
        wr(`EPI_OFS_MASK, 8'h00);
        rd(`EPI_OFS_MASK);
        chk("mask", 8'h00, rd_val);
        chk("event irq", 8'h00, {7'h00, event_irq_ff});
        wr(`EPI_OFS_STATUS, 8'h03);
        rd(`EPI_OFS_STATUS);
        chk("status", 8'h00, rd_val);
        print_verdict();
    end
endmodule // ext_pin_int_tb
`default_nettype wire
